// File: src/ptb_pkg.sv
// shared constants for the trip blanking window block
// assumes one pwm module clock domain, no software-visible registers
package ptb_pkg;
	// unblanked cycles at the start of every window
	localparam int unsigned PTB_LEAD_CYCLES = 3;
	// cycles after window close during which a falling trip may glitch
	localparam int unsigned PTB_TAIL_CYCLES = 3;
	// default widths of counter and event fields
	localparam int unsigned PTB_CNT_W = 16;
	localparam int unsigned PTB_EVT_W = 4;
	localparam logic [1:0] PTB_LEAD_INIT = 2'h0;
	typedef enum logic [1:0] {
		PTB_IDLE,
		PTB_LEAD,
		PTB_BLANK
	} ptb_state_t;
endpackage

// File: src/ptb_edge_counter.sv
// small saturating down-counter used for the tail cycle span
// assumes load and the pwm clock come from the main blanking module
module ptb_edge_counter #(
	parameter int unsigned W = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic busy
);
	// a zero-width counter could never flag a span
	if (W < 1) begin : g_bad_w
		$error("ptb_edge_counter: unsupported width");
	end

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	assign cnt_next = load ? load_val : ((cnt_reg != '0) ? cnt_reg - 1'h1 : cnt_reg);
	assign busy = (cnt_reg != '0);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// File: src/ptb_blanking_window.sv
// blanking window for compare-derived trip events of a pulse width unit
// assumes raw_compare_event and time-base count are synchronous to clk
module ptb_blanking_window
	import ptb_pkg::*;
#(
	parameter int unsigned CNT_W = PTB_CNT_W,
	parameter int unsigned EVT_W = PTB_EVT_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [CNT_W-1:0] tb_count,
	input wire logic [CNT_W-1:0] blank_start,
	input wire logic [CNT_W-1:0] blank_width,
	input wire logic blank_enable,
	input wire logic filt_enable,
	input wire logic [EVT_W-1:0] raw_compare_event,
	output logic [EVT_W-1:0] filtered_compare_event,
	output logic window_open,
	output logic lead_active,
	output logic close_hazard
);
	// lead and tail counters are two bits wide
	if (CNT_W < 2 || EVT_W < 1 || PTB_LEAD_CYCLES < 1 || PTB_LEAD_CYCLES > 4
		|| PTB_TAIL_CYCLES > 3) begin : g_bad_cfg
		$error("ptb_blanking_window: unsupported width or cycle count");
	end

	////////////////////////////////////////////////////////////////////
	ptb_state_t state_reg;
	ptb_state_t state_next;
	logic [CNT_W-1:0] remain_reg;
	logic [CNT_W-1:0] remain_next;
	logic [EVT_W-1:0] filt_reg;
	logic [EVT_W-1:0] filt_next;
	logic [1:0] lead_reg;
	logic [1:0] lead_next;
	logic start_hit;
	logic open_now;
	logic masking;
	logic closing;
	logic tail_busy;
	logic any_raw;

	// one step of the window countdown, shared by lead and blank states
	function automatic logic [CNT_W-1:0] dec_remain(input logic [CNT_W-1:0] v);
		return v - 1'h1;
	endfunction

	// start is a time-base match, width counts clocks from there
	assign start_hit = blank_enable && (tb_count == blank_start) && (blank_width != '0);
	assign open_now = (state_reg != PTB_IDLE);
	// lead cycles leak events through: silicon behaviour kept on purpose
	assign masking = (state_reg == PTB_BLANK);
	assign closing = open_now && (remain_reg == CNT_W'(1));
	assign any_raw = |raw_compare_event;

	always_comb begin
		state_next = state_reg;
		remain_next = remain_reg;
		lead_next = lead_reg;
		// no reset on tb_count wrap: window outlives the period
		case (state_reg)
			PTB_IDLE: begin
				if (start_hit) begin
					state_next = PTB_LEAD;
					remain_next = blank_width;
					lead_next = 2'(PTB_LEAD_CYCLES - 1);
				end
			end
			PTB_LEAD: begin
				remain_next = dec_remain(remain_reg);
				lead_next = (lead_reg != PTB_LEAD_INIT) ? lead_reg - 1'h1 : lead_reg;
				if (closing) begin
					state_next = PTB_IDLE;
				end else if (lead_reg == PTB_LEAD_INIT) begin
					state_next = PTB_BLANK;
				end
			end
			PTB_BLANK: begin
				remain_next = dec_remain(remain_reg);
				if (closing) begin
					state_next = PTB_IDLE;
				end
			end
			default: begin
				state_next = PTB_IDLE;
			end
		endcase
	end

	// filtered output follows raw except while blanking or while filt_enable is low
	assign filt_next = (!filt_enable) ? '0 : (masking ? '0 : raw_compare_event);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= PTB_IDLE;
			remain_reg <= '0;
			lead_reg <= PTB_LEAD_INIT;
			filt_reg <= '0;
		end else begin
			state_reg <= state_next;
			remain_reg <= remain_next;
			lead_reg <= lead_next;
			filt_reg <= filt_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// flags the span after close where a falling trip can glitch output
	ptb_edge_counter #(
		.W(2)
	) u_tail (
		.clk(clk),
		.rst_b(rst_b),
		.load(closing),
		.load_val(2'(PTB_TAIL_CYCLES)),
		.busy(tail_busy)
	);

	assign filtered_compare_event = filt_reg;
	assign window_open = open_now;
	assign lead_active = (state_reg == PTB_LEAD);
	// either outcome is legal here; software must avoid it by sizing
	assign close_hazard = (tail_busy || closing) && any_raw;

	////////////////////////////////////////////////////////////////////
	property p_mask_blank;
		@(posedge clk) disable iff (!rst_b)
		(state_reg == PTB_BLANK) |=> (filtered_compare_event == '0);
	endproperty
	a_mask_blank: assert property (p_mask_blank) else $error("event leaked in blanking");

	property p_lead_len;
		@(posedge clk) disable iff (!rst_b)
		($rose(lead_active) && blank_width > CNT_W'(4)) |-> lead_active [*3] ##1 masking;
	endproperty
	a_lead_len: assert property (p_lead_len) else $error("lead span not three cycles");

	property p_lead_pass;
		@(posedge clk) disable iff (!rst_b)
		(lead_active && filt_enable) |=> (filtered_compare_event == $past(raw_compare_event));
	endproperty
	a_lead_pass: assert property (p_lead_pass) else $error("lead span did not pass events");

	property p_filt_off;
		@(posedge clk) disable iff (!rst_b)
		!filt_enable |=> (filtered_compare_event == '0);
	endproperty
	a_filt_off: assert property (p_filt_off) else $error("disabled filter drove output");

	property p_wrap_keep;
		@(posedge clk) disable iff (!rst_b)
		(masking && !closing && tb_count == '0) |=> window_open;
	endproperty
	a_wrap_keep: assert property (p_wrap_keep) else $error("window ended on wrap");

	property p_width;
		@(posedge clk) disable iff (!rst_b)
		($rose(window_open) && blank_width == CNT_W'(5)) |-> window_open [*5] ##1 !window_open;
	endproperty
	a_width: assert property (p_width) else $error("window width wrong");

	property p_tail;
		@(posedge clk) disable iff (!rst_b)
		($fell(window_open) && any_raw) |-> close_hazard;
	endproperty
	a_tail: assert property (p_tail) else $error("close hazard missed");

	// a later close reloads the tail, so only an undisturbed span must end
	property p_tail_end;
		@(posedge clk) disable iff (!rst_b)
		($past(closing, 4) && !$past(closing, 3) && !$past(closing, 2) && !$past(closing)
			&& !closing) |-> !close_hazard;
	endproperty
	a_tail_end: assert property (p_tail_end) else $error("close hazard too long");

	property p_lead_start;
		@(posedge clk) disable iff (!rst_b)
		(!window_open && start_hit) |=> (lead_active && window_open);
	endproperty
	a_lead_start: assert property (p_lead_start) else $error("window did not open");

	property p_stay_open;
		@(posedge clk) disable iff (!rst_b)
		(window_open && !closing) |=> window_open;
	endproperty
	a_stay_open: assert property (p_stay_open) else $error("window ended early");

	property p_count;
		@(posedge clk) disable iff (!rst_b)
		(window_open && !closing) |=> (remain_reg == CNT_W'($past(remain_reg) - 1));
	endproperty
	a_count: assert property (p_count) else $error("window count did not step");

	property p_follow;
		@(posedge clk) disable iff (!rst_b)
		(!masking && filt_enable) |=> (filtered_compare_event == $past(raw_compare_event));
	endproperty
	a_follow: assert property (p_follow) else $error("unmasked event not passed");

	property p_tail_span;
		@(posedge clk) disable iff (!rst_b)
		closing |=> tail_busy [*3];
	endproperty
	a_tail_span: assert property (p_tail_span) else $error("tail span too short");

	property p_close_flag;
		@(posedge clk) disable iff (!rst_b)
		(closing && any_raw) |-> close_hazard;
	endproperty
	a_close_flag: assert property (p_close_flag) else $error("closing hazard missed");

	property p_short;
		@(posedge clk) disable iff (!rst_b)
		($rose(window_open) && blank_width == CNT_W'(1))
			|-> (lead_active && closing) ##1 !window_open;
	endproperty
	a_short: assert property (p_short) else $error("short window wrong");

	property p_blank_after_lead;
		@(posedge clk) disable iff (!rst_b)
		$rose(masking) |-> $past(lead_active);
	endproperty
	a_blank_after_lead: assert property (p_blank_after_lead) else $error("blank without lead");
endmodule

// File: verification/ptb_trip_src.sv
// trip event source model for the blanking window bench
// assumes the block samples events on rising clk edges
module ptb_trip_src (
	input wire logic clk,
	input wire logic slow,
	output logic [3:0] ev
);
	timeunit 1ns;
	timeprecision 1ns;
	integer seed = 32'h8417_0306;
	// slow mode holds trips long enough to straddle a window close
	initial begin
		ev = 4'h0;
		forever begin
			@(negedge clk);
			if (!slow || ($random(seed) & 3) == 0) ev <= 4'($random(seed));
		end
	end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the trip blanking window block
// assumes ptb_trip_src drives raw events on falling clk edges
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ptb_pkg::*;
	logic clk = 0, rst_b = 0, blank_enable = 0, filt_enable = 0, slow = 0, wo, la, hz;
	logic [15:0] tb_count = 0, blank_start = 0, blank_width = 0;
	logic [3:0] raw, filt, exp_f = 0;
	integer seed = 32'h8417_0306, n_mismatch = 0, n_compared = 0, rem = 0, age = 0, tail = 0;
	int k = 0;
	logic pend = 0;
	// start 13 opens 3 cycles before the 16-count period wraps; width 20 outlasts a period
	logic [15:0] cs [7] = '{16'h000d, 16'h0002, 16'h0005, 16'h0000, 16'h0004, 16'h0003,
		16'h0007};
	logic [15:0] cw [7] = '{16'h0005, 16'h0001, 16'h0003, 16'h0000, 16'h0014, 16'h0002,
		16'h0004};
	ptb_blanking_window uut (.clk(clk), .rst_b(rst_b), .tb_count(tb_count),
		.blank_start(blank_start), .blank_width(blank_width), .blank_enable(blank_enable),
		.filt_enable(filt_enable), .raw_compare_event(raw), .filtered_compare_event(filt),
		.window_open(wo), .lead_active(la), .close_hazard(hz));
	ptb_trip_src src (.clk(clk), .slow(slow), .ev(raw));
	initial forever #10 clk = ~clk;
	task automatic cmp_evt(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// masking starts only once the lead cycles have passed
	function automatic logic [3:0] exp_filt(input logic en, input int r, input int a,
		input logic [3:0] ev);
		return (en && !(r != 0 && a >= PTB_LEAD_CYCLES)) ? ev : 4'h0;
	endfunction
	// closing cycle plus the tail span, only while some trip is raised
	function automatic logic exp_hazard(input int r, input int t, input logic [3:0] ev);
		return (r == 1 || t != 0) && ev != 4'h0;
	endfunction
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rem = 0;
			age = 0;
			tail = 0;
			exp_f = 4'h0;
		end else begin
			exp_f = exp_filt(filt_enable, rem, age, raw);
			tail = (rem == 1) ? PTB_TAIL_CYCLES : (tail > 0 ? tail - 1 : 0);
			if (rem != 0) begin
				rem--;
				age++;
			end else if (blank_enable && tb_count == blank_start && blank_width != 0) begin
				rem = blank_width;
				age = 0;
			end
		end
	end
	// compare first, then drive, all on the falling edge
	always @(negedge clk) begin
		cmp_evt(filt, exp_f);
		cmp_flag(wo, rem != 0);
		cmp_flag(la, rem != 0 && age < PTB_LEAD_CYCLES);
		cmp_flag(hz, exp_hazard(rem, tail, raw));
		tb_count <= (tb_count == 16'h000f) ? 16'h0000 : tb_count + 16'h0001;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge clk);
		rst_b <= 1'h1;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk);
			if (i == 300) rst_b <= 1'h0;
			if (i == 303) rst_b <= 1'h1;
			if (i % 40 == 0) pend = 1'h1;
			// window shape only changes while idle; a pending corner waits, never skipped
			if (pend && rem == 0) begin
				pend = 1'h0;
				blank_start <= (k < 7) ? cs[k] : 16'($random(seed) & 15);
				blank_width <= (k < 7) ? cw[k] : 16'($random(seed) & 15);
				// seventh corner leaves matching disarmed
				blank_enable <= (k < 7) ? (k != 6) : (($random(seed) & 7) != 0);
				// third corner runs its window with the filter off
				filt_enable <= (k < 7) ? (k != 2) : (($random(seed) & 7) != 0);
				slow <= ($random(seed) & 1) != 0;
				k++;
			end
		end
		tally_and_finish;
	end
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule
